// ===== hdl/btel_ident.sv
`timescale 1ns/1ps
// maps a violating source to its requester identity code
module btel_ident (
  input  wire btel_pkg::btel_src_e source,
  input  wire logic                processor_priority_select,
  input  wire logic                dma_priority_select,
  output      logic [7:0]          requester_ident
);
  import btel_pkg::*;

  always_comb begin
    case (source)
      BTEL_SRC_CPU:     requester_ident = processor_priority_select ? ID_CPU_HI : ID_CPU_LO;
      BTEL_SRC_DMA_RD:  requester_ident = dma_priority_select ? ID_DMA_RD_HI : ID_DMA_RD_LO;
      BTEL_SRC_DMA_WR:  requester_ident = dma_priority_select ? ID_DMA_WR_HI : ID_DMA_WR_LO;
      BTEL_SRC_USB:     requester_ident = ID_USB;
      BTEL_SRC_ETH_RD:  requester_ident = ID_ETH_RD;
      BTEL_SRC_ETH_WR:  requester_ident = ID_ETH_WR;
      BTEL_SRC_CAN_ONE: requester_ident = ID_CAN_ONE;
      BTEL_SRC_CAN_TWO: requester_ident = ID_CAN_TWO;
      BTEL_SRC_QSPI:    requester_ident = ID_QSPI;
      BTEL_SRC_FLASH:   requester_ident = ID_FLASH;
      BTEL_SRC_CRYPTO:  requester_ident = ID_CRYPTO;
      default:          requester_ident = 8'h00;
    endcase
  end

endmodule : btel_ident

// ===== hdl/btel_logger.sv
`timescale 1ns/1ps
module btel_logger (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire btel_pkg::btel_viol_s violation,
  input  wire logic                 processor_priority_select,
  input  wire logic                 dma_priority_select,
  input  wire logic [15:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output      logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output      logic                 s_axi_wready,
  output      logic [1:0]           s_axi_bresp,
  output      logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [15:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output      logic                 s_axi_arready,
  output      logic [31:0]          s_axi_rdata,
  output      logic [1:0]           s_axi_rresp,
  output      logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output      logic                 error_report_enable,
  output      logic                 irq
);
  import btel_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  btel_log_s   log_q;
  logic [31:0] control;
  logic [31:0] r0_setup, r0_read, r0_write;
  logic [31:0] r2_setup, r2_read, r2_write;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [7:0]  ident_now;
  logic        aw_held, w_held;
  logic [15:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        log_empty;
  logic        ev_capture, ev_multi;
  logic        clr_multi, clr_code, clr_single_hit, clr_multi_hit;
  logic [31:0] log_word, next_rdata;
  logic        rd_ok;

  btel_ident u_ident (
    .source                    (violation.source),
    .processor_priority_select (processor_priority_select),
    .dma_priority_select       (dma_priority_select),
    .requester_ident           (ident_now)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] keep);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & keep;
  endfunction : merge

  function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
    return {a[15:2], 2'b00} == reg_addr;
  endfunction : hit

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_held       <= 1'b0;
      aw_addr       <= 16'h0000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (hit(aw_addr, ADDR_CONTROL) || hit(aw_addr, ADDR_LOG_FIRST)
                      || hit(aw_addr, ADDR_CLR_SINGLE) || hit(aw_addr, ADDR_CLR_MULTI)
                      || hit(aw_addr, ADDR_R0_SETUP) || hit(aw_addr, ADDR_R0_READ)
                      || hit(aw_addr, ADDR_R0_WRITE) || hit(aw_addr, ADDR_R2_SETUP)
                      || hit(aw_addr, ADDR_R2_READ) || hit(aw_addr, ADDR_R2_WRITE)
                      || hit(aw_addr, ADDR_IRQ_STATUS) || hit(aw_addr, ADDR_IRQ_MASK)
                      || hit(aw_addr, ADDR_LOG_SECOND)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // error log capture and clearing
  // ************************************************************
  assign log_empty  = (log_q.code == CODE_NONE);
  assign ev_capture = violation.valid && log_empty;
  assign ev_multi   = violation.valid && !log_empty;
  assign clr_multi  = wr_fire && hit(aw_addr, ADDR_LOG_FIRST) && w_strb[3]
                      && w_data[MULTI_BIT];
  assign clr_code   = wr_fire && hit(aw_addr, ADDR_LOG_FIRST) && w_strb[3]
                      && (w_data[CODE_LSB +: 4] != 4'h0);
  // the clear aliases wipe the record or the multi flag on any write
  assign clr_single_hit = wr_fire && hit(aw_addr, ADDR_CLR_SINGLE);
  assign clr_multi_hit  = wr_fire && hit(aw_addr, ADDR_CLR_MULTI);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      log_q <= '0;
    end else begin
      // a new error in the clearing cycle wins over a multi clear; a record clear still wipes an occupied log
      if (ev_multi) begin
        log_q.multi <= 1'b1;
      end else if (clr_multi || clr_multi_hit) begin
        log_q.multi <= 1'b0;
      end
      if (ev_capture) begin
        log_q.code    <= CODE_PERMISSION;
        log_q.ident   <= ident_now;
        log_q.region  <= violation.region;
        log_q.command <= violation.command;
        log_q.group   <= violation.group;
      end else if (clr_code || clr_single_hit) begin
        log_q.code    <= CODE_NONE;
        log_q.ident   <= 8'h00;
        log_q.region  <= 4'h0;
        log_q.command <= 3'h0;
        log_q.group   <= 2'h0;
      end
    end
  end

  // ************************************************************
  // control, region registers and interrupt
  // ************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      control  <= RESET_WORD;
      r0_setup <= SETUP_FIXED_ONES;
      r0_read  <= RESET_WORD;
      r0_write <= RESET_WORD;
      r2_setup <= SETUP_FIXED_ONES;
      r2_read  <= RESET_WORD;
      r2_write <= RESET_WORD;
      irq_mask <= 2'b00;
    end else if (wr_fire) begin
      if (hit(aw_addr, ADDR_CONTROL))
        control <= merge(control, w_data, w_strb, 32'h1 << ERR_REPORT_BIT);
      if (hit(aw_addr, ADDR_R0_SETUP))
        r0_setup <= merge(r0_setup, w_data, w_strb, SETUP_READ_MASK) | SETUP_FIXED_ONES;
      if (hit(aw_addr, ADDR_R0_READ))
        r0_read <= merge(r0_read, w_data, w_strb, GROUP_MASK);
      if (hit(aw_addr, ADDR_R0_WRITE))
        r0_write <= merge(r0_write, w_data, w_strb, GROUP_MASK);
      if (hit(aw_addr, ADDR_R2_SETUP))
        r2_setup <= merge(r2_setup, w_data, w_strb, SETUP_READ_MASK) | SETUP_FIXED_ONES;
      if (hit(aw_addr, ADDR_R2_READ))
        r2_read <= merge(r2_read, w_data, w_strb, GROUP_MASK);
      if (hit(aw_addr, ADDR_R2_WRITE))
        r2_write <= merge(r2_write, w_data, w_strb, GROUP_MASK);
      if (hit(aw_addr, ADDR_IRQ_MASK) && w_strb[0])
        irq_mask <= w_data[1:0];
    end
  end

  // status bit 0: first error logged, bit 1: further error while occupied
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? ev_capture : ev_multi) begin
          irq_status[i] <= 1'b1;
        end else if (wr_fire && hit(aw_addr, ADDR_IRQ_STATUS) && w_strb[0] && w_data[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq                 <= 1'b0;
      error_report_enable <= 1'b0;
    end else begin
      irq                 <= |(irq_status & irq_mask);
      error_report_enable <= control[ERR_REPORT_BIT];
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  always_comb begin
    log_word = 32'h0000_0000;
    log_word[MULTI_BIT]         = log_q.multi;
    log_word[CODE_LSB +: 4]     = log_q.code;
    log_word[IDENT_LSB +: 8]    = log_q.ident;
    log_word[REGION_LSB +: 4]   = log_q.region;
    log_word[CMD_LSB +: 3]      = log_q.command;
  end

  always_comb begin
    rd_ok      = 1'b1;
    next_rdata = 32'h0000_0000;
    case ({s_axi_araddr[15:2], 2'b00})
      ADDR_LOG_FIRST:  next_rdata = log_word;
      ADDR_LOG_SECOND: next_rdata = {30'h0, log_q.group};
      ADDR_CONTROL:    next_rdata = control;
      ADDR_CLR_SINGLE: next_rdata = 32'h0000_0000;
      ADDR_CLR_MULTI:  next_rdata = 32'h0000_0000;
      ADDR_R0_SETUP:   next_rdata = r0_setup;
      ADDR_R0_READ:    next_rdata = r0_read;
      ADDR_R0_WRITE:   next_rdata = r0_write;
      ADDR_R2_SETUP:   next_rdata = r2_setup;
      ADDR_R2_READ:    next_rdata = r2_read;
      ADDR_R2_WRITE:   next_rdata = r2_write;
      ADDR_IRQ_STATUS: next_rdata = {30'h0, irq_status};
      ADDR_IRQ_MASK:   next_rdata = {30'h0, irq_mask};
      default:         rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence second_error_s;
    violation.valid && !log_empty && !(clr_code || clr_single_hit);
  endsequence

  multi_sets_a: assert property (@(posedge clock) disable iff (!reset_n)
    second_error_s |=> log_q.multi) else $error("multi flag not set");
  multi_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    clr_multi && !ev_multi |=> !log_q.multi) else $error("multi flag not cleared");
  code_values_a: assert property (@(posedge clock) disable iff (!reset_n)
    log_q.code == CODE_NONE || log_q.code == CODE_PERMISSION) else $error("bad code");
  code_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    clr_code && !ev_capture |=> log_q.code == CODE_NONE) else $error("code not cleared");
  cpu_ident_a: assert property (@(posedge clock) disable iff (!reset_n)
    ev_capture && violation.source == BTEL_SRC_CPU |=>
      log_q.ident == ($past(processor_priority_select) ? ID_CPU_HI : ID_CPU_LO))
    else $error("processor identity wrong");
  usb_ident_a: assert property (@(posedge clock) disable iff (!reset_n)
    ev_capture && violation.source == BTEL_SRC_USB |=> log_q.ident == ID_USB)
    else $error("usb identity wrong");
  zero_bits_a: assert property (@(posedge clock) disable iff (!reset_n)
    s_axi_rvalid && $past(s_axi_araddr) == ADDR_LOG_FIRST && $past(s_axi_arready)
      |-> s_axi_rdata[30:28] == 3'b000 && s_axi_rdata[23:16] == 8'h00)
    else $error("unimplemented bits nonzero");
  log_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    ev_multi && !clr_code && !clr_single_hit |=> $stable(log_q.ident) && $stable(log_q.region))
    else $error("occupied log overwritten");

endmodule : btel_logger

// ===== hdl/btel_pkg.sv
package btel_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [15:0] ADDR_LOG_FIRST   = 16'h9020;
  localparam logic [15:0] ADDR_LOG_SECOND  = 16'h9024;
  localparam logic [15:0] ADDR_CONTROL     = 16'h9028;
  localparam logic [15:0] ADDR_CLR_SINGLE  = 16'h9030;
  localparam logic [15:0] ADDR_CLR_MULTI   = 16'h9038;
  localparam logic [15:0] ADDR_R0_SETUP    = 16'h9040;
  localparam logic [15:0] ADDR_R0_READ     = 16'h9050;
  localparam logic [15:0] ADDR_R0_WRITE    = 16'h9058;
  localparam logic [15:0] ADDR_R2_SETUP    = 16'h9080;
  localparam logic [15:0] ADDR_R2_READ     = 16'h9090;
  localparam logic [15:0] ADDR_R2_WRITE    = 16'h9098;
  localparam logic [15:0] ADDR_IRQ_STATUS  = 16'h90C0;
  localparam logic [15:0] ADDR_IRQ_MASK    = 16'h90C4;

  // ************************************************************
  // field positions and values
  // ************************************************************
  localparam int          MULTI_BIT        = 31;
  localparam int          CODE_LSB         = 24;
  localparam int          IDENT_LSB        = 8;
  localparam int          REGION_LSB       = 4;
  localparam int          CMD_LSB          = 0;
  localparam int          ERR_REPORT_BIT   = 24;
  localparam logic [3:0]  CODE_NONE        = 4'h0;
  localparam logic [3:0]  CODE_PERMISSION  = 4'h3;
  localparam logic [31:0] SETUP_READ_MASK  = 32'hFFFF_FEF8;
  localparam logic [31:0] SETUP_FIXED_ONES = 32'h0003_0000;
  localparam logic [31:0] GROUP_MASK       = 32'h0000_000F;
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;

  // requester identities
  localparam logic [7:0]  ID_CPU_LO        = 8'h01;
  localparam logic [7:0]  ID_CPU_HI        = 8'h02;
  localparam logic [7:0]  ID_DMA_RD_LO     = 8'h03;
  localparam logic [7:0]  ID_DMA_RD_HI     = 8'h04;
  localparam logic [7:0]  ID_DMA_WR_LO     = 8'h05;
  localparam logic [7:0]  ID_DMA_WR_HI     = 8'h06;
  localparam logic [7:0]  ID_USB           = 8'h07;
  localparam logic [7:0]  ID_ETH_RD        = 8'h08;
  localparam logic [7:0]  ID_ETH_WR        = 8'h09;
  localparam logic [7:0]  ID_CAN_ONE       = 8'h0A;
  localparam logic [7:0]  ID_CAN_TWO       = 8'h0B;
  localparam logic [7:0]  ID_QSPI          = 8'h0C;
  localparam logic [7:0]  ID_FLASH         = 8'h0D;
  localparam logic [7:0]  ID_CRYPTO        = 8'h0E;

  typedef enum logic [3:0] {
    BTEL_SRC_CPU, BTEL_SRC_DMA_RD, BTEL_SRC_DMA_WR, BTEL_SRC_USB,
    BTEL_SRC_ETH_RD, BTEL_SRC_ETH_WR, BTEL_SRC_CAN_ONE, BTEL_SRC_CAN_TWO,
    BTEL_SRC_QSPI, BTEL_SRC_FLASH, BTEL_SRC_CRYPTO, BTEL_SRC_NONE
  } btel_src_e;

  // one permission violation as reported by the bus target
  typedef struct packed {
    logic      valid;
    btel_src_e source;
    logic [3:0] region;
    logic [2:0] command;
    logic [1:0] group;
  } btel_viol_s;

  typedef struct packed {
    logic       multi;
    logic [3:0] code;
    logic [7:0] ident;
    logic [3:0] region;
    logic [2:0] command;
    logic [1:0] group;
  } btel_log_s;

endpackage : btel_pkg

// ===== verification/btel_initiators.sv
`timescale 1ns/1ps
// ************************************************************
// bus initiators raising permission violations
// ************************************************************
module btel_initiators (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                req_go,
  input  wire btel_pkg::btel_src_e req_src,
  input  wire logic [3:0]          req_region,
  input  wire logic [2:0]          req_cmd,
  input  wire logic [1:0]          req_group,
  output      btel_pkg::btel_viol_s violation
);
  import btel_pkg::*;

  // one-cycle pulse per request
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      violation <= '0;
    end else if (req_go) begin
      violation <= {1'b1, req_src, req_region, req_cmd, req_group};
    end else begin
      // idle fields keep toggling so sampling without valid shows up
      violation <= {1'b0, ~violation[12:0]};
    end
  end
endmodule : btel_initiators

// ===== verification/bus_target_error_logger_tb.sv
`timescale 1ns/1ps
module bus_target_error_logger_tb;
  import btel_pkg::*;
  logic clock = 0, reset_n = 0, go = 0, cs = 0, ds = 0;
  btel_src_e src = BTEL_SRC_CPU;
  logic [3:0] rg = 4'h0, strb = 4'h0;
  logic [2:0] cmd = 3'h0;
  logic [1:0] grp = 2'h0, rsp, bresp, rresp;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awr, wr_rdy, bvalid, arr, rvalid, ere, irq;
  btel_viol_s viol;
  int error_cnt = 0, checks_done = 0;
  always #10 clock = ~clock;

  btel_initiators u_init (.clock(clock), .reset_n(reset_n), .req_go(go), .req_src(src),
    .req_region(rg), .req_cmd(cmd), .req_group(grp), .violation(viol));
  btel_logger u_dut (.clock(clock), .reset_n(reset_n), .violation(viol),
    .processor_priority_select(cs), .dma_priority_select(ds),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .error_report_enable(ere), .irq(irq));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] dt, input logic [3:0] s);
    bit ad, wd, bd;
    int n;
    ad = 0; wd = 0; bd = 0; n = 0;
    @(posedge clock);
    awaddr <= a; awv <= 1; wdata <= dt; strb <= s; wv <= 1; bready <= 1;
    while (!bd && n < 100) begin
      @(posedge clock);
      n++;
      if (!ad && awr === 1'b1) begin ad = 1; awv <= 0; end
      if (!wd && wr_rdy === 1'b1) begin wd = 1; wv <= 0; end
      if (ad && wd && bvalid === 1'b1) begin bd = 1; rsp = bresp; bready <= 0; end
    end
    if (!bd) chk("write timeout", 32'h0000_0001, 32'h0000_0000);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    bit ad, rdn;
    int n;
    ad = 0; rdn = 0; n = 0;
    @(posedge clock);
    araddr <= a; arv <= 1; rready <= 1;
    while (!rdn && n < 100) begin
      @(posedge clock);
      n++;
      if (!ad && arr === 1'b1) begin ad = 1; arv <= 0; end
      if (ad && rvalid === 1'b1) begin rdn = 1; d = rdata; rsp = rresp; rready <= 0; end
    end
    if (!rdn) chk("read timeout", 32'h0000_0001, 32'h0000_0000);
  endtask : rd

  task automatic fire(input btel_src_e s);
    @(posedge clock);
    go <= 1; src <= s; rg <= 4'($urandom); cmd <= 3'($urandom); grp <= 2'($urandom);
    @(posedge clock);
    go <= 0;
    repeat (4) @(posedge clock);
  endtask : fire

  function automatic logic [7:0] ident(btel_src_e s, logic c, logic dm);
    case (s)
      BTEL_SRC_CPU:     return c ? ID_CPU_HI : ID_CPU_LO;
      BTEL_SRC_DMA_RD:  return dm ? ID_DMA_RD_HI : ID_DMA_RD_LO;
      BTEL_SRC_DMA_WR:  return dm ? ID_DMA_WR_HI : ID_DMA_WR_LO;
      BTEL_SRC_USB:     return ID_USB;
      BTEL_SRC_ETH_RD:  return ID_ETH_RD;
      BTEL_SRC_ETH_WR:  return ID_ETH_WR;
      BTEL_SRC_CAN_ONE: return ID_CAN_ONE;
      BTEL_SRC_CAN_TWO: return ID_CAN_TWO;
      BTEL_SRC_QSPI:    return ID_QSPI;
      BTEL_SRC_FLASH:   return ID_FLASH;
      default:          return ID_CRYPTO;
    endcase
  endfunction : ident

  function automatic logic [31:0] logw(logic m, logic [7:0] id, logic [3:0] r, logic [2:0] c);
    return {m, 3'b000, CODE_PERMISSION, 8'h00, id, r, 1'b0, c};
  endfunction : logw

  // ************************************************************
  // main sequence
  // ************************************************************
  logic [15:0] ra [11] = '{ADDR_LOG_FIRST, ADDR_LOG_SECOND, ADDR_CONTROL, ADDR_CLR_SINGLE,
    ADDR_CLR_MULTI, ADDR_R0_SETUP, ADDR_R0_READ, ADDR_R0_WRITE, ADDR_R2_SETUP,
    ADDR_R2_READ, ADDR_R2_WRITE};
  logic [31:0] w, ex;
  logic [7:0] idn;
  logic [3:0] crg;
  logic [2:0] ccmd;
  initial begin
    void'($urandom(32'h4c4b));
    repeat (10) @(posedge clock);
    reset_n <= 1;
    for (int i = 0; i < 11; i++) begin
      rd(ra[i]);
      ex = (i == 5 || i == 8) ? SETUP_FIXED_ONES : RESET_WORD;
      chk("reset value", d, ex);
    end
    rd(16'h9000);
    chk("unmapped read resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(16'h9004, 32'hFFFF_FFFF, 4'hF);
    chk("unmapped write resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 11; i++) begin
      w = $urandom;
      wr(ra[5 + (i % 6)], w, 4'hF);
      rd(ra[5 + (i % 6)]);
      ex = (i % 3 == 0) ? ((w & SETUP_READ_MASK) | SETUP_FIXED_ONES) : (w & GROUP_MASK);
      chk("region reg", d, ex);
    end
    for (int i = 0; i < 22; i++) begin
      @(posedge clock);
      cs <= (i >= 11) ^ i[0];
      ds <= (i >= 11);
      fire(btel_src_e'(i % 11));
      idn = ident(btel_src_e'(i % 11), (i >= 11) ^ i[0], i >= 11);
      crg = rg;
      ccmd = cmd;
      rd(ADDR_LOG_FIRST);
      chk("log first", d, logw(1'b0, idn, crg, ccmd));
      rd(ADDR_LOG_SECOND);
      chk("log second", d, {30'h0, grp});
      chk("irq masked", {31'h0, irq}, 32'h0000_0000);
      fire(btel_src_e'((i + 3) % 11));
      rd(ADDR_LOG_FIRST);
      chk("log multi", d, logw(1'b1, idn, crg, ccmd));
      wr(ADDR_LOG_FIRST, 32'h8000_0000, 4'b1000);
      rd(ADDR_LOG_FIRST);
      chk("multi cleared", d, logw(1'b0, idn, crg, ccmd));
      if (i[0]) wr(ADDR_LOG_FIRST, 32'h0F00_0000, 4'b1000);
      else wr(ADDR_CLR_SINGLE, 32'h0000_0001, 4'hF);
      rd(ADDR_LOG_FIRST);
      chk("log cleared", d, RESET_WORD);
    end
    // ************************************************************
    // interrupt and control
    // ************************************************************
    wr(ADDR_IRQ_STATUS, 32'h0000_0003, 4'hF);
    wr(ADDR_IRQ_MASK, 32'h0000_0003, 4'hF);
    fire(BTEL_SRC_USB);
    chk("irq raised", {31'h0, irq}, 32'h0000_0001);
    fire(BTEL_SRC_FLASH);
    rd(ADDR_IRQ_STATUS);
    chk("irq status", d, 32'h0000_0003);
    wr(ADDR_CLR_MULTI, 32'h0000_0001, 4'hF);
    rd(ADDR_LOG_FIRST);
    chk("clear multi reg", {24'h0, d[31:24]}, {24'h0, 4'h0, CODE_PERMISSION});
    wr(ADDR_IRQ_STATUS, 32'h0000_0001, 4'hF);
    repeat (2) @(posedge clock);
    chk("irq held", {31'h0, irq}, 32'h0000_0001);
    wr(ADDR_IRQ_STATUS, 32'h0000_0002, 4'hF);
    repeat (3) @(posedge clock);
    chk("irq dropped", {31'h0, irq}, 32'h0000_0000);
    wr(ADDR_CONTROL, 32'hFFFF_FFFF, 4'hF);
    rd(ADDR_CONTROL);
    chk("control", d, 32'h0100_0000);
    chk("report enable", {31'h0, ere}, 32'h0000_0001);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
endmodule : bus_target_error_logger_tb
